/* File: verilog/nip_pkg.sv */
// Shared constants and types of the nested interrupt enable, pending and priority controller.
`default_nettype none

package nip_pkg;

	// -----------------------------------------------------------------
	// Sizing
	// -----------------------------------------------------------------
	localparam int          NUM_IRQ    = 42;          // Interrupt lines served.
	localparam int          ID_W       = 9;           // Width of an interrupt number.
	localparam int          PRIO_W     = 4;           // Stored priority bits per interrupt.
	localparam int          ADDR_W     = 12;          // APB byte address width.
	localparam int          NUM_PRIO_W = 11;          // Priority words implemented.

	// -----------------------------------------------------------------
	// Register byte offsets
	// -----------------------------------------------------------------
	localparam logic [11:0] OFF_EN_SET   = 12'h100;   // Enable set words 0..7.
	localparam logic [11:0] OFF_EN_CLR   = 12'h180;   // Enable clear words 0..7.
	localparam logic [11:0] OFF_PEND_SET = 12'h200;   // Pending set words 0..7.
	localparam logic [11:0] OFF_PEND_CLR = 12'h280;   // Pending clear words 0..7.
	localparam logic [11:0] OFF_ACTIVE   = 12'h300;   // Active flag words 0..7.
	localparam logic [11:0] OFF_PRIO     = 12'h400;   // Priority words 0..10.
	localparam logic [11:0] OFF_TRIGGER  = 12'hF00;   // Software trigger word.

	// -----------------------------------------------------------------
	// Field layout and reset values
	// -----------------------------------------------------------------
	localparam int          PRIO_LSB     = 4;         // Stored nibble sits in bits 7:4 of a lane.
	localparam int          LANES        = 4;         // Priority lanes per word.
	localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
	localparam logic [3:0]  RESET_PRIO   = 4'h0;
	localparam logic [3:0]  LOWEST_PRIO  = 4'hF;      // Numerically largest value.

	// Register groups that an APB address can select.
	typedef enum logic [2:0] {
		K_EN_SET,
		K_EN_CLR,
		K_PEND_SET,
		K_PEND_CLR,
		K_ACTIVE,
		K_PRIO,
		K_TRIGGER,
		K_BAD
	} nip_kind_t;

	// One APB request as seen by the slave.
	typedef struct packed {
		logic              sel;
		logic              enable;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
		logic [3:0]        strb;
	} nip_apb_req_t;

	// Whole state of the controller.
	typedef struct packed {
		logic [NUM_IRQ-1:0]             en;        // Enabled interrupts.
		logic [NUM_IRQ-1:0]             pend;      // Pending interrupts.
		logic [NUM_IRQ-1:0]             act;       // Active interrupts.
		logic [NUM_IRQ-1:0]             lvl_prev;  // Request levels of the last cycle.
		logic [NUM_IRQ-1:0][PRIO_W-1:0] prio;      // Priority nibbles.
		logic                           req;       // An interrupt is offered.
		logic [ID_W-1:0]                num;       // Number of the offered interrupt.
		logic [PRIO_W-1:0]              top_prio;  // Priority of the offered interrupt.
		logic [31:0]                    prdata;    // Read data for the access phase.
		logic                           pslverr;   // Error answer for the access phase.
	} nip_state_t;

endpackage : nip_pkg

`default_nettype wire

/* File: verilog/nip_sync.sv */
// Two-stage synchroniser for the asynchronous interrupt request pins.
`timescale 1ns/10ps
`default_nettype none

module nip_sync #(
	parameter int WIDTH = 1                    // Number of lines.
) (
	input  wire logic             clk_i,       // Core clock.
	input  wire logic             reset_n_i,   // Asynchronous reset, active low.
	input  wire logic [WIDTH-1:0] async_i,     // Lines from outside the domain.
	output logic      [WIDTH-1:0] sync_o       // Lines safe to read.
);

	logic [WIDTH-1:0] meta_r;                  // First stage, read only by the second.

	// -----------------------------------------------------------------
	// Sync chain
	// -----------------------------------------------------------------
	// Both stages clear on reset so no request is seen before release.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_r <= '0;
			sync_o <= '0;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end

endmodule // nip_sync

`default_nettype wire

/* File: verilog/nip_ctrl.sv */
// Interrupt controller: enables, pending and active flags, priorities and APB registers.
//
// Operation
// - enable-set writes of 1 enable; read enables
// - pending and enabled interrupts compete by priority
// - disabled interrupts pend but are never offered
// - enable-clear writes of 1 disable; read enables
// - pending-set writes of 1 pend; read pending
// - pending-set on pending interrupt changes nothing
// - pending-set also pends disabled interrupts
// - pending-clear writes of 1 unpend; read pending
// - pending-clear leaves active state untouched
// - active word reads 1 when active
// - four byte-wide priority lanes per word
// - priority 0 to 15, lower wins
// - only upper nibble stored, lower reads zero
// - interrupt m in word m/4, lane m%4
// - trigger write pends numbered interrupt 0-239; the code pends only 0-41 and ignores larger numbers
// - high level while inactive or rising edge pends
// - handler entry moves pending to active
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module nip_ctrl (
	input  wire logic                            MCLK_I,         // Core clock, 250 MHz.
	input  wire logic                            RESET_N_I,      // Asynchronous reset, active low.
	input  wire logic                            PSEL_I,         // APB select.
	input  wire logic                            PENABLE_I,      // APB access phase.
	input  wire logic                            PWRITE_I,       // APB direction, high writes.
	input  wire logic [nip_pkg::ADDR_W-1:0]      PADDR_I,        // APB byte address.
	input  wire logic [31:0]                     PWDATA_I,       // APB write data.
	input  wire logic [3:0]                      PSTRB_I,        // APB byte strobes.
	output logic      [31:0]                     PRDATA_O,       // APB read data.
	output logic                                 PREADY_O,       // APB ready.
	output logic                                 PSLVERR_O,      // APB error.
	input  wire logic [nip_pkg::NUM_IRQ-1:0]     IRQ_LINES_I,    // Peripheral request pins.
	output logic                                 IRQ_REQ_O,      // An interrupt is offered.
	output logic      [nip_pkg::ID_W-1:0]        IRQ_NUM_O,      // Offered interrupt number.
	output logic      [nip_pkg::PRIO_W-1:0]      IRQ_PRIO_O,     // Offered interrupt priority.
	input  wire logic                            CORE_ACK_I,     // Core enters a handler.
	input  wire logic [nip_pkg::ID_W-1:0]        CORE_ACK_NUM_I, // Interrupt being entered.
	input  wire logic                            CORE_EOI_I,     // Core returns from a handler.
	input  wire logic [nip_pkg::ID_W-1:0]        CORE_EOI_NUM_I  // Interrupt being left.
);

	localparam int N = nip_pkg::NUM_IRQ;

	nip_pkg::nip_state_t   s_r;          // Registered state.
	nip_pkg::nip_state_t   s_nxt;        // Next state.
	nip_pkg::nip_apb_req_t apb;          // Bundled bus request.
	logic [N-1:0]          lvl;          // Synchronised request levels.

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------

	// Maps a byte address onto the register group it selects.
	function automatic nip_pkg::nip_kind_t decode(input logic [nip_pkg::ADDR_W-1:0] a);
		nip_pkg::nip_kind_t k;
		k = nip_pkg::K_BAD;
		if (a[11:5] == nip_pkg::OFF_EN_SET[11:5])
			k = nip_pkg::K_EN_SET;
		else if (a[11:5] == nip_pkg::OFF_EN_CLR[11:5])
			k = nip_pkg::K_EN_CLR;
		else if (a[11:5] == nip_pkg::OFF_PEND_SET[11:5])
			k = nip_pkg::K_PEND_SET;
		else if (a[11:5] == nip_pkg::OFF_PEND_CLR[11:5])
			k = nip_pkg::K_PEND_CLR;
		else if (a[11:5] == nip_pkg::OFF_ACTIVE[11:5])
			k = nip_pkg::K_ACTIVE;
		else if (a[11:6] == nip_pkg::OFF_PRIO[11:6] && int'(a[5:2]) < nip_pkg::NUM_PRIO_W)
			k = nip_pkg::K_PRIO;
		else if (a[11:2] == nip_pkg::OFF_TRIGGER[11:2])
			k = nip_pkg::K_TRIGGER;
		if (a[1:0] != 2'h0)
			k = nip_pkg::K_BAD;   // Unaligned addresses are refused.
		return k;
	endfunction

	// Places a 32-bit word of flags onto the interrupt vector at word index w.
	function automatic logic [N-1:0] spread(input logic [31:0] d, input logic [2:0] w);
		logic [N-1:0] r;
		r = '0;
		for (int i = 0; i < N; i++) begin
			if (i / 32 == int'(w))
				r[i] = d[i % 32];
		end
		return r;
	endfunction

	// Gathers word index w of an interrupt vector; missing lines read zero.
	function automatic logic [31:0] gather(input logic [N-1:0] v, input logic [2:0] w);
		logic [31:0] r;
		r = 32'h0000_0000;
		for (int i = 0; i < N; i++) begin
			if (i / 32 == int'(w))
				r[i % 32] = v[i];
		end
		return r;
	endfunction

	// One-hot vector for an interrupt number; out-of-range numbers give zero.
	function automatic logic [N-1:0] onehot(input logic hit, input logic [nip_pkg::ID_W-1:0] n);
		logic [N-1:0] r;
		r = '0;
		for (int i = 0; i < N; i++) begin
			if (hit && int'(n) == i)
				r[i] = 1'b1;
		end
		return r;
	endfunction

	// -----------------------------------------------------------------
	// Input synchronisation
	// -----------------------------------------------------------------
	// Request pins come from peripherals in other domains.
	nip_sync #(
		.WIDTH     (N)
	) u_sync (
		.clk_i     (MCLK_I),
		.reset_n_i (RESET_N_I),
		.async_i   (IRQ_LINES_I),
		.sync_o    (lvl)
	);

	assign apb.sel    = PSEL_I;
	assign apb.enable = PENABLE_I;
	assign apb.write  = PWRITE_I;
	assign apb.addr   = PADDR_I;
	assign apb.wdata  = PWDATA_I;
	assign apb.strb   = PSTRB_I;

	// -----------------------------------------------------------------
	// Next-state logic
	// -----------------------------------------------------------------
	// The slave never waits, so a write takes effect at the end of its access cycle.
	// Read data is captured in the setup cycle so it comes from a flip-flop.
	always_comb begin
		nip_pkg::nip_kind_t kind;
		logic               wr;
		logic               setup;
		logic [31:0]        wmask;
		logic [N-1:0]       wbits;
		logic [N-1:0]       rise;
		logic [N-1:0]       ack_v;
		logic [N-1:0]       eoi_v;
		logic [N-1:0]       trig_v;
		logic [N-1:0]       p_set;
		logic [N-1:0]       p_clr;
		logic [N-1:0]       elig;
		logic [31:0]        rd;
		int                 m;
		s_nxt  = s_r;
		kind   = decode(apb.addr);
		wr     = apb.sel && apb.enable && apb.write;
		setup  = apb.sel && !apb.enable;
		wmask  = {{8{apb.strb[3]}}, {8{apb.strb[2]}}, {8{apb.strb[1]}}, {8{apb.strb[0]}}};
		wbits  = spread(apb.wdata & wmask, apb.addr[4:2]);
		rise   = lvl & ~s_r.lvl_prev;
		ack_v  = onehot(CORE_ACK_I, CORE_ACK_NUM_I);
		eoi_v  = onehot(CORE_EOI_I, CORE_EOI_NUM_I);
		trig_v = onehot(wr && kind == nip_pkg::K_TRIGGER && apb.strb[1:0] == 2'h3,
			apb.wdata[nip_pkg::ID_W-1:0]);
		rd     = 32'h0000_0000;
		m      = 0;
		// Defaults keep every local of this process defined on every path.
		p_set  = '0;
		p_clr  = '0;
		elig   = '0;

		s_nxt.lvl_prev = lvl;

		// Enable flags: set and clear views share one store.
		if (wr && kind == nip_pkg::K_EN_SET)
			s_nxt.en = s_r.en | wbits;
		else if (wr && kind == nip_pkg::K_EN_CLR)
			s_nxt.en = s_r.en & ~wbits;

		// Pending sources; the level term is masked while the handler is entered.
		p_set = (lvl & ~s_r.act & ~ack_v) | rise | trig_v;
		if (wr && kind == nip_pkg::K_PEND_SET)
			p_set = p_set | wbits;
		p_clr = ack_v;
		if (wr && kind == nip_pkg::K_PEND_CLR)
			p_clr = p_clr | wbits;
		// Hardware sets win over a clear in the same cycle; a set of a pending bit keeps it.
		s_nxt.pend = (s_r.pend & ~p_clr) | p_set;

		// Active flags change only on handler entry and return, never on pending clear.
		s_nxt.act = (s_r.act & ~eoi_v) | ack_v;

		// Priority lanes: each strobed byte lane stores its upper nibble only.
		if (wr && kind == nip_pkg::K_PRIO) begin
			for (int b = 0; b < nip_pkg::LANES; b++) begin
				m = int'(apb.addr[5:2]) * nip_pkg::LANES + b;
				if (apb.strb[b] && m < N)
					s_nxt.prio[m] = apb.wdata[b*8+nip_pkg::PRIO_LSB +: nip_pkg::PRIO_W];
			end
		end

		// Arbitration over registered state; strict compare keeps the lowest number on ties.
		elig           = s_r.pend & s_r.en;
		s_nxt.req      = 1'b0;
		s_nxt.num      = '0;
		s_nxt.top_prio = nip_pkg::LOWEST_PRIO;
		for (int i = 0; i < N; i++) begin
			if (elig[i] && (!s_nxt.req || s_r.prio[i] < s_nxt.top_prio)) begin
				s_nxt.req      = 1'b1;
				s_nxt.num      = nip_pkg::ID_W'(i);
				s_nxt.top_prio = s_r.prio[i];
			end
		end

		// Read data and error answer, prepared in the setup cycle.
		if (setup) begin
			case (kind)
				nip_pkg::K_EN_SET, nip_pkg::K_EN_CLR: begin
					rd = gather(s_r.en, apb.addr[4:2]);
				end
				nip_pkg::K_PEND_SET, nip_pkg::K_PEND_CLR: begin
					rd = gather(s_r.pend, apb.addr[4:2]);
				end
				nip_pkg::K_ACTIVE: begin
					rd = gather(s_r.act, apb.addr[4:2]);
				end
				nip_pkg::K_PRIO: begin
					for (int b = 0; b < nip_pkg::LANES; b++) begin
						m = int'(apb.addr[5:2]) * nip_pkg::LANES + b;
						if (m < N)
							rd[b*8 +: 8] = {s_r.prio[m], 4'h0};
					end
				end
				default: begin
					rd = 32'h0000_0000;   // Trigger is write-only; unmapped reads zero.
				end
			endcase
			s_nxt.prdata  = apb.write ? 32'h0000_0000 : rd;
			s_nxt.pslverr = (kind == nip_pkg::K_BAD);
		end
	end

	// -----------------------------------------------------------------
	// State register
	// -----------------------------------------------------------------
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			s_r          <= '0;
			s_r.prio     <= {N{nip_pkg::RESET_PRIO}};
			s_r.prdata   <= nip_pkg::RESET_WORD;
		end else begin
			s_r <= s_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	// Zero wait states keep the core's register accesses short.
	assign PREADY_O   = 1'b1;
	assign PRDATA_O   = s_r.prdata;
	assign PSLVERR_O  = s_r.pslverr;
	assign IRQ_REQ_O  = s_r.req;
	assign IRQ_NUM_O  = s_r.num;
	assign IRQ_PRIO_O = s_r.top_prio;

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RESET_N_I);

	logic wr_acc;        // Write completing this cycle.
	logic wr_word0;      // Write targets word 0 with lane 0 strobed.
	assign wr_acc   = PSEL_I && PENABLE_I && PWRITE_I;
	assign wr_word0 = wr_acc && PADDR_I[4:2] == 3'h0 && PSTRB_I[0] && PWDATA_I[0];

	// Enabled and pending lines as the arbiter sees them; offers lag this by one edge.
	logic [N-1:0] elig_now;
	assign elig_now = s_r.en & s_r.pend;

	a_enable_set_bit: assert property (
		wr_word0 && PADDR_I == nip_pkg::OFF_EN_SET |=> s_r.en[0])
		else $error("Enable set write did not enable interrupt 0");

	a_enable_clear_bit: assert property (
		wr_word0 && PADDR_I == nip_pkg::OFF_EN_CLR |=> !s_r.en[0])
		else $error("Enable clear write did not disable interrupt 0");

	// The number is taken now and the eligible set one edge back, when it was chosen.
	a_offer_needs_enable: assert property (
		IRQ_REQ_O |-> |($past(elig_now) & onehot(1'b1, IRQ_NUM_O)))
		else $error("Offered interrupt was not enabled and pending");

	a_pend_set_bit: assert property (
		wr_word0 && PADDR_I == nip_pkg::OFF_PEND_SET && !CORE_ACK_I |=> s_r.pend[0])
		else $error("Pending set write did not pend interrupt 0");

	// Only a clear that no level or edge of line 0 can override is judged.
	a_pend_clear_bit: assert property (
		wr_word0 && PADDR_I == nip_pkg::OFF_PEND_CLR && !lvl[0] |=> !s_r.pend[0])
		else $error("Pending clear write did not unpend interrupt 0");

	a_pend_clear_active: assert property (
		wr_acc && PADDR_I[11:5] == nip_pkg::OFF_PEND_CLR[11:5] && !CORE_ACK_I && !CORE_EOI_I
		|=> s_r.act == $past(s_r.act))
		else $error("Pending clear changed an active flag");

	a_prio_low_nibble: assert property (
		PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I[11:6] == nip_pkg::OFF_PRIO[11:6]
		##1 PENABLE_I |-> PRDATA_O[3:0] == 4'h0 && PRDATA_O[11:8] == 4'h0)
		else $error("Priority lane low nibble read non-zero");

	a_trigger_pends: assert property (
		wr_acc && PADDR_I == nip_pkg::OFF_TRIGGER && PSTRB_I[1:0] == 2'h3
		&& PWDATA_I[8:0] == 9'h003 |=> s_r.pend[3])
		else $error("Software trigger did not pend interrupt 3");

	a_ack_to_active: assert property (
		CORE_ACK_I && CORE_ACK_NUM_I == 9'h009 |=> s_r.act[9] ##1 s_r.act[9] || $past(CORE_EOI_I))
		else $error("Handler entry did not mark interrupt 9 active");

	a_rise_pends: assert property (
		$rose(lvl[9]) |=> s_r.pend[9])
		else $error("Rising request edge did not pend interrupt 9");

	a_offer_priority: assert property (
		IRQ_REQ_O && $past(elig_now[4]) |-> IRQ_PRIO_O <= $past(s_r.prio[4]))
		else $error("Offered interrupt is less urgent than interrupt 4");

	// With nothing eligible the offer must drop and show number zero one edge later.
	a_no_offer_idle: assert property (
		!(|elig_now) |=> !IRQ_REQ_O && IRQ_NUM_O == 9'h000)
		else $error("Interrupt offered with none enabled and pending");

	c_offer_seen: cover property (IRQ_REQ_O ##1 CORE_ACK_I);
	c_prio_write: cover property (wr_acc && PADDR_I[11:6] == nip_pkg::OFF_PRIO[11:6]);
	c_bad_access: cover property (PSEL_I && PENABLE_I && PSLVERR_O);
	c_trigger: cover property (wr_acc && PADDR_I == nip_pkg::OFF_TRIGGER);

endmodule // nip_ctrl

`default_nettype wire

/* File: test/nip_core_model.sv */
// Behavioural processor core that enters and leaves interrupt handlers.
`timescale 1ns/10ps
`default_nettype none

module nip_core_model (
	input  wire logic                     clk_i,     // Core clock.
	input  wire logic                     reset_n_i, // Asynchronous reset, active low.
	input  wire logic                     req_i,     // An interrupt is offered.
	input  wire logic [nip_pkg::ID_W-1:0] num_i,     // Offered number.
	input  wire logic                     take_i,    // Bench allows handler entry.
	input  wire logic                     leave_i,   // Bench asks for handler return.
	output logic                          ack_o,     // Handler entry pulse.
	output logic      [nip_pkg::ID_W-1:0] ack_num_o, // Number being entered.
	output logic                          eoi_o,     // Handler return pulse.
	output logic      [nip_pkg::ID_W-1:0] eoi_num_o  // Number being left.
);
	logic                     busy_r; // A handler is running.
	logic [nip_pkg::ID_W-1:0] cur_r;  // Number of the running handler.

	// One handler at a time; the offer lags an ack by two edges, so a busy
	// core never acknowledges a stale offer. Idle numbers toggle each cycle.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ack_o     <= 1'b0;
			eoi_o     <= 1'b0;
			busy_r    <= 1'b0;
			cur_r     <= 9'h000;
			ack_num_o <= 9'h000;
			eoi_num_o <= 9'h000;
		end else begin
			ack_o     <= 1'b0;
			eoi_o     <= 1'b0;
			ack_num_o <= ~ack_num_o;
			eoi_num_o <= ~eoi_num_o;
			if (!busy_r && take_i && req_i) begin
				ack_o     <= 1'b1;
				ack_num_o <= num_i;
				cur_r     <= num_i;
				busy_r    <= 1'b1;
			end else if (busy_r && leave_i) begin
				eoi_o     <= 1'b1;
				eoi_num_o <= cur_r;
				busy_r    <= 1'b0;
			end
		end
	end
endmodule // nip_core_model

`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench of the interrupt controller over APB and a core model.
`timescale 1ns/10ps
`default_nettype none

module tb;
	localparam logic [11:0] ES = nip_pkg::OFF_EN_SET;
	localparam logic [11:0] EC = nip_pkg::OFF_EN_CLR;
	localparam logic [11:0] PS = nip_pkg::OFF_PEND_SET;
	localparam logic [11:0] PC = nip_pkg::OFF_PEND_CLR;
	localparam logic [11:0] AC = nip_pkg::OFF_ACTIVE;
	localparam logic [11:0] PR = nip_pkg::OFF_PRIO;
	localparam logic [11:0] TR = nip_pkg::OFF_TRIGGER;

	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] padr = 12'h000;
	logic [31:0] pwd = 32'h0, prd;
	logic [3:0]  pstrb = 4'hF;
	logic        prdy, perr, req, ack, eoi, take = 1'b0, leave = 1'b0;
	logic [41:0] lines = '0;
	logic [8:0]  num, ack_num, eoi_num;
	logic [3:0]  prio;
	int          fail_count = 0, checks_done = 0, cyc = 0;

	always #2 clk = ~clk;

	nip_ctrl DUT (.MCLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PSTRB_I(pstrb), .PRDATA_O(prd),
		.PREADY_O(prdy), .PSLVERR_O(perr), .IRQ_LINES_I(lines), .IRQ_REQ_O(req),
		.IRQ_NUM_O(num), .IRQ_PRIO_O(prio), .CORE_ACK_I(ack), .CORE_ACK_NUM_I(ack_num),
		.CORE_EOI_I(eoi), .CORE_EOI_NUM_I(eoi_num));

	nip_core_model CORE (.clk_i(clk), .reset_n_i(rst_n), .req_i(req), .num_i(num),
		.take_i(take), .leave_i(leave), .ack_o(ack), .ack_num_o(ack_num), .eoi_o(eoi),
		.eoi_num_o(eoi_num));

	// -----------------------------------------------------------------
	// Shared tasks
	// -----------------------------------------------------------------
	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Compares one value; an unknown never matches.
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	// One APB transfer; an idle edge first keeps drivers from double assignment.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic er);
		@(posedge clk);
		psel <= 1'b1; pen <= 1'b0; pwr <= w; padr <= a; pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (prdy !== 1'b1) begin
			@(posedge clk);
		end
		q = prd;
		er = perr;
		psel <= 1'b0; pen <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic er;
		apb(1'b1, a, d, q, er);
	endtask

	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		logic er;
		apb(1'b0, a, 32'h0, q, er);
		chk(nm, e, q);
	endtask

	// The offer settles one edge after a state change.
	task automatic offer(input logic r, input logic [8:0] n, input logic [3:0] p);
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk("offer", {18'h0, r, n, p}, {18'h0, req, num, prio});
	endtask

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	task automatic s_enable;
		rdc("en_rst", ES, 32'h0);
		rdc("prio_rst", PR, 32'h0);
		wr(ES, 32'h5);
		rdc("en_set", ES, 32'h5);
		wr(ES, 32'h0);
		rdc("en_zero", EC, 32'h5);
		wr(EC, 32'h1);
		rdc("en_clr", ES, 32'h4);
		wr(EC, 32'h4);
		wr(ES + 12'h4, 32'h200);
		rdc("en_w1", EC + 12'h4, 32'h200);
		wr(EC + 12'h4, 32'h200);
		rdc("en_w1c", ES + 12'h4, 32'h0);
	endtask

	task automatic s_pend;
		wr(PS + 12'h4, 32'h1);
		rdc("pend_dis", PC + 12'h4, 32'h1);
		offer(1'b0, 9'h000, 4'hF);
		wr(PS, 32'h1);
		rdc("pend_w0", PC, 32'h1);
		wr(PC, 32'h1);
		rdc("unpend_w0", PS, 32'h0);
		wr(PS + 12'h4, 32'h1);
		wr(PC + 12'h4, 32'h0);
		rdc("pend_again", PS + 12'h4, 32'h1);
		wr(PC + 12'h4, 32'h1);
		rdc("pend_clr", PS + 12'h4, 32'h0);
	endtask

	// Lane order, nibble storage and arbitration by value, then by number.
	task automatic s_prio;
		wr(PR + 12'h4, 32'hFFFFFFFF);
		rdc("prio_nib", PR + 12'h4, 32'hF0F0F0F0);
		wr(PR + 12'h4, 32'h00103020);
		rdc("prio_lane", PR + 12'h4, 32'h00103020);
		wr(ES, 32'h70);
		wr(PS, 32'h70);
		offer(1'b1, 9'h006, 4'h1);
		wr(PR + 12'h4, 32'h00102020);
		wr(PC, 32'h40);
		offer(1'b1, 9'h004, 4'h2);
		wr(PC, 32'h30);
		wr(EC, 32'h70);
		offer(1'b0, 9'h000, 4'hF);
	endtask

	task automatic s_trig;
		wr(TR, 32'h3);
		rdc("trig", PS, 32'h8);
		wr(TR, 32'h2A);
		rdc("trig_big", PS, 32'h8);
		rdc("trig_rd", TR, 32'h0);
		wr(PC, 32'h8);
	endtask

	// A pin raises interrupt 9; the core enters, software pends and unpends it.
	task automatic s_line;
		int n;
		n = 0;
		wr(ES, 32'h200);
		lines[9] <= 1'b1;
		take <= 1'b1;
		while (ack !== 1'b1 && n < 30) begin
			n++;
			@(posedge clk);
		end
		chk("ack_num", 32'h9, {23'h0, ack_num});
		lines[9] <= 1'b0;
		take <= 1'b0;
		rdc("act", AC, 32'h200);
		rdc("pend_gone", PS, 32'h0);
		wr(AC, 32'hFFFFFFFF);
		wr(PS, 32'h200);
		rdc("act_pend", AC, 32'h200);
		wr(PC, 32'h200);
		rdc("act_keep", AC, 32'h200);
		@(posedge clk);
		leave <= 1'b1;
		@(posedge clk);
		leave <= 1'b0;
		rdc("act_end", AC, 32'h0);
		wr(EC, 32'h200);
	endtask

	task automatic s_err;
		logic [31:0] q;
		logic er;
		apb(1'b0, 12'h102, 32'h0, q, er);
		chk("err_unal", 32'h1, {31'h0, er});
		apb(1'b0, 12'h800, 32'h0, q, er);
		chk("err_map", 32'h1, {31'h0, er});
		apb(1'b0, ES + 12'h8, 32'h0, q, er);
		chk("word2", 32'h0, {31'h0, er});
	endtask

	// Cuts a hang short.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			report_and_stop();
		end
	end

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		s_enable();
		s_pend();
		s_prio();
		s_trig();
		s_line();
		s_err();
		report_and_stop();
	end
endmodule // tb

`default_nettype wire
